// ==== core/backlight_regs.vh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef BACKLIGHT_REGS_VH
`define BACKLIGHT_REGS_VH

`define ADDR_BRIGHTNESS     8'h00
`define ADDR_DEVICE_CONTROL 8'h01
`define ADDR_FAULT_FLAGS    8'h02
`define ADDR_IDENTIFICATION 8'h03
`define ADDR_OUTPUT_FORCE   8'h04
`define ADDR_TEMP_HIGH      8'h05
`define ADDR_TEMP_LOW       8'h06

`define RST_DEVICE_CONTROL  8'h00
`define RST_OUTPUT_FORCE    8'h00
`define RST_BRIGHTNESS      8'h00

`define BIT_BACKLIGHT_ON    0
`define SRC_MSB             2
`define SRC_LSB             1
`define SRC_REGISTER        2'b10
`define SRC_PASS_THROUGH    2'b11

`define FLT_OPEN            7
`define FLT_SHORT           6
`define FLT_MULTI_CHANNEL   5
`define FLT_ONE_CHANNEL     4
`define FLT_ANY_LED         3
`define FLT_OVERCURRENT     2
`define FLT_THERMAL         1
`define FLT_UNDERVOLTAGE    0

`define TEMP_HIGH_MSB       10
`define TEMP_HIGH_LSB       3
`define TEMP_LOW_FIELD_MSB  7
`define TEMP_LOW_FIELD_LSB  5

`define BOOST_LOW_TIME_MS   50
`define CLK_FREQ_HZ         200000000
`define BOOST_LOW_CYCLES    (`BOOST_LOW_TIME_MS * (`CLK_FREQ_HZ / 1000))

`endif

// ==== core/pin_sync.v ====
// Two-flop synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             rstn,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   always @(posedge clk) begin
      if (!rstn) begin
         stage1   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ==== core/backlight_control_status_regs.v ====
// Control and status registers of a four-channel LED backlight driver.
//
// Overview of operation
// - Fault bit 7 sets on an open LED output and reads 0 with no fault.
// - Fault bit 6 sets on a shorted LED output and reads 0 with no fault.
// - Fault bit 5 sets when two or more channels reported open or short.
// - Fault bit 4 sets when exactly one channel reported open or short.
// - Fault bit 3 is the OR of all individual LED fault conditions.
// - Fault flags stay set until a fault register read or enable pin low.
// - While any fault flag is set the open-drain fault pin is pulled low.
// - Boost output low over 50 ms sets overcurrent flag, disables boost.
// - Once the overcurrent flag is cleared the boost restarts by itself.
// - Over-temperature sets thermal flag, boost and LEDs off until cooled.
// - Undervoltage sets its flag, boost and LEDs off until supply recovers.
// - Each output force bit drives its LED at 100% duty, else normal PWM.
// - Temperature high read latches 11 bits and returns 10:3; read it first.
// - Temperature low returns the three latched LSBs in bits 7:5.
`timescale 1ns/1ps
`include "backlight_regs.vh"
module backlight_control_status_regs #(
   // The identification value is arbitrary.
   parameter [7:0]  ID_VALUE         = 8'h5A,
   parameter [31:0] BOOST_LOW_CYCLES = `BOOST_LOW_CYCLES
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   input  wire        chip_enable_pin,
   input  wire        pwm_pin,
   input  wire [3:0]  pwm_pin_duty_out,
   input  wire [3:0]  brightness_pwm_out,
   input  wire [3:0]  led_open_det,
   input  wire [3:0]  led_short_det,
   input  wire        boost_output_low,
   input  wire        over_temp_hot,
   input  wire        over_temp_cooled,
   input  wire        supply_input_low,
   input  wire        supply_input_recovered,
   input  wire [10:0] temperature_raw,
   output reg  [7:0]  brightness_level,
   output reg  [1:0]  brightness_source_select,
   output reg         backlight_on,
   output reg  [3:0]  led_drive,
   output reg         boost_enable,
   output reg         fault_pin_out,
   output reg         fault_pin_oe_n
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // The enable, PWM and detector pins each pass two flops before use; temperature_raw and the two duty inputs are used directly.
   wire [14:0] pin_s;
   pin_sync #(
      .WIDTH (15)
   ) u_sync (
      .clk      (clk),
      .rstn     (rstn),
      .async_in ({chip_enable_pin, pwm_pin, led_open_det, led_short_det,
                  boost_output_low, over_temp_hot, over_temp_cooled,
                  supply_input_low, supply_input_recovered}),
      .sync_out (pin_s)
   );
   wire       en_s   = pin_s[14];
   wire       pwm_s  = pin_s[13];
   wire [3:0] open_s = pin_s[12:9];
   wire [3:0] shrt_s = pin_s[8:5];
   wire       blow_s = pin_s[4];
   wire       hot_s  = pin_s[3];
   wire       cool_s = pin_s[2];
   wire       uv_s   = pin_s[1];
   wire       uvok_s = pin_s[0];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   reg [7:0]  output_force_full;
   reg [7:0]  fault_flags;
   reg [3:0]  ch_fault;
   reg [10:0] temp_latch;
   reg [31:0] low_count;
   reg        thermal_hold;
   reg        uv_hold;

   wire rd_fault = reg_rd && (reg_addr == `ADDR_FAULT_FLAGS);
   wire clr_all  = rd_fault || !en_s;
   wire [3:0] ch_now  = open_s | shrt_s;
   wire [3:0] ch_seen = ch_fault | ch_now;
   // Distinct channels since the last clear are counted, so a fault that
   // moves from one channel to another still reads as two channels.
   wire [2:0] ch_count = {2'b00, ch_seen[0]} + {2'b00, ch_seen[1]} +
                         {2'b00, ch_seen[2]} + {2'b00, ch_seen[3]};
   wire multi = ch_count > 3'd1;
   wire boost_trip = blow_s && (low_count >= BOOST_LOW_CYCLES);

   reg [7:0] new_events;
   always @* begin
      new_events = 8'h00;
      new_events[`FLT_OPEN]          = |open_s;
      new_events[`FLT_SHORT]         = |shrt_s;
      new_events[`FLT_MULTI_CHANNEL] = |ch_now && multi;
      new_events[`FLT_ONE_CHANNEL]   = |ch_now && !multi;
      new_events[`FLT_ANY_LED]       = |ch_now;
      new_events[`FLT_OVERCURRENT]   = boost_trip;
      new_events[`FLT_THERMAL]       = hot_s;
      new_events[`FLT_UNDERVOLTAGE]  = uv_s;
   end

   // ---------------------------------------------------------------
   // Register writes and sticky flags
   // ---------------------------------------------------------------
   // New events win over a clear in the same cycle so none is lost.
   always @(posedge clk) begin
      if (!rstn) begin
         brightness_level         <= `RST_BRIGHTNESS;
         brightness_source_select <= 2'b00;
         backlight_on             <= 1'b0;
         output_force_full        <= `RST_OUTPUT_FORCE;
         fault_flags              <= 8'h00;
         ch_fault                 <= 4'h0;
         temp_latch               <= 11'h000;
         low_count                <= 32'h0000_0000;
         thermal_hold             <= 1'b0;
         uv_hold                  <= 1'b0;
      end else begin
         if (reg_wr) begin
            // Writes to any other offset are dropped.
            case (reg_addr)
               `ADDR_BRIGHTNESS: brightness_level <= reg_wdata;
               `ADDR_DEVICE_CONTROL: begin
                  brightness_source_select <=
                     reg_wdata[`SRC_MSB:`SRC_LSB];
                  backlight_on <= reg_wdata[`BIT_BACKLIGHT_ON];
               end
               `ADDR_OUTPUT_FORCE: output_force_full <= {4'h0, reg_wdata[3:0]};
               default: ;
            endcase
         end
         if (clr_all) begin
            fault_flags <= new_events;
            ch_fault    <= ch_now;
         end else begin
            fault_flags <= fault_flags | new_events;
            ch_fault    <= ch_seen;
         end
         // Counter saturates; it clears once the boost output recovers or boost_enable drops.
         if (!blow_s || !boost_enable)
            low_count <= 32'h0000_0000;
         else if (low_count < BOOST_LOW_CYCLES)
            low_count <= low_count + 32'h0000_0001;
         // The holds release only on their recovery inputs, never on a
         // fault read, so software cannot restart a hot or starved part.
         if (hot_s)
            thermal_hold <= 1'b1;
         else if (cool_s)
            thermal_hold <= 1'b0;
         if (uv_s)
            uv_hold <= 1'b1;
         else if (uvok_s)
            uv_hold <= 1'b0;
         if (reg_rd && reg_addr == `ADDR_TEMP_HIGH)
            temp_latch <= temperature_raw;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_BRIGHTNESS:     reg_rdata <= brightness_level;
            `ADDR_DEVICE_CONTROL: reg_rdata <= {5'b00000,
                                     brightness_source_select, backlight_on};
            `ADDR_FAULT_FLAGS:    reg_rdata <= fault_flags | new_events;
            `ADDR_IDENTIFICATION: reg_rdata <= ID_VALUE;
            `ADDR_OUTPUT_FORCE:   reg_rdata <= output_force_full;
            `ADDR_TEMP_HIGH:      reg_rdata <=
               temperature_raw[`TEMP_HIGH_MSB:`TEMP_HIGH_LSB];
            `ADDR_TEMP_LOW:       reg_rdata <=
               {temp_latch[2:0], 5'b00000};
            default:              reg_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Output drive
   // ---------------------------------------------------------------
   reg [3:0] next_led;
   always @* begin
      case (brightness_source_select)
         `SRC_REGISTER:     next_led = brightness_pwm_out;
         `SRC_PASS_THROUGH: next_led = {4{pwm_s}};
         default:           next_led = pwm_pin_duty_out;
      endcase
      next_led = next_led | output_force_full[3:0];
      if (!backlight_on || thermal_hold || uv_hold)
         next_led = 4'h0;
   end

   always @(posedge clk) begin
      if (!rstn) begin
         led_drive      <= 4'h0;
         boost_enable   <= 1'b0;
         fault_pin_out  <= 1'b0;
         fault_pin_oe_n <= 1'b1;
      end else begin
         led_drive <= next_led;
         // Boost comes back once the overcurrent flag is gone.
         boost_enable <= backlight_on && !thermal_hold && !uv_hold &&
                         !fault_flags[`FLT_OVERCURRENT] && !boost_trip;
         fault_pin_out  <= 1'b0;
         fault_pin_oe_n <= ~|fault_flags;
      end
   end

endmodule

// ==== dv/bl_regs_sva.sv ====
// Port assertions for the backlight control and status registers.
`timescale 1ns/1ps
module bl_regs_sva #(
   parameter [7:0] ID_VALUE = 8'h00
) (
   input wire        clk,
   input wire        rstn,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire [7:0]  reg_rdata,
   input wire [3:0]  led_open_det,
   input wire [3:0]  led_short_det,
   input wire        over_temp_hot,
   input wire        supply_input_low,
   input wire [10:0] temperature_raw,
   input wire [1:0]  brightness_source_select,
   input wire        backlight_on,
   input wire [3:0]  led_drive,
   input wire        boost_enable,
   input wire        fault_pin_out,
   input wire        fault_pin_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_ctrl_write: assert property (
      reg_wr && reg_addr == 8'h01 |=> {brightness_source_select,
      backlight_on} == $past(reg_wdata[2:0])) else $error("ctrl lost");
   a_id_read: assert property (
      reg_rd && reg_addr == 8'h03 |=> reg_rdata == ID_VALUE)
      else $error("id wrong");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr > 8'h06 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_temp_high: assert property (
      reg_rd && reg_addr == 8'h05 |=>
      reg_rdata == $past(temperature_raw[10:3])) else $error("temp hi");
   a_temp_low: assert property (
      reg_rd && reg_addr == 8'h05 ##1 !reg_rd ##1
      reg_rd && reg_addr == 8'h06 |=> reg_rdata ==
      {$past(temperature_raw[2:0], 3), 5'h00}) else $error("temp lo");
   a_open_pin: assert property (
      (led_open_det != 4'h0)[*6] |-> !fault_pin_oe_n)
      else $error("pin idle on open");
   a_short_pin: assert property (
      (led_short_det != 4'h0)[*6] |-> !fault_pin_oe_n)
      else $error("pin idle on short");
   a_pin_low_only: assert property (
      !fault_pin_oe_n |-> fault_pin_out == 1'b0) else $error("pin high");
   a_hot_off: assert property (
      over_temp_hot[*6] |-> !boost_enable && led_drive == 4'h0)
      else $error("hot not off");
   a_uv_off: assert property (
      supply_input_low[*6] |-> !boost_enable && led_drive == 4'h0)
      else $error("uv not off");
endmodule
bind backlight_control_status_regs bl_regs_sva #(.ID_VALUE(ID_VALUE)) i_sva (
   .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .led_open_det(led_open_det), .led_short_det(led_short_det),
   .over_temp_hot(over_temp_hot), .supply_input_low(supply_input_low),
   .temperature_raw(temperature_raw), .backlight_on(backlight_on),
   .brightness_source_select(brightness_source_select),
   .led_drive(led_drive), .boost_enable(boost_enable),
   .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n));

// ==== dv/tb_top.sv ====
// Self-checking bench for the backlight register block.
`timescale 1ns/1ps
module tb_top;
   localparam [7:0] ID = 8'h3C; // Arbitrary identification value.
   reg clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, en = 1, pin = 0;
   reg hot = 0, cool = 0, uvl = 0, uvr = 0, blow = 0;
   reg [7:0] reg_addr = 0, reg_wdata = 0, r, f;
   reg [3:0] pduty = 0, bpwm = 0, opn = 0, sht = 0;
   reg [10:0] traw = 0;
   reg [31:0] lf = 32'h8004_cb9a;
   wire [7:0] reg_rdata, blev;
   wire [1:0] src;
   wire [3:0] led;
   wire bl, boost, foen, fout;
   int fail_count = 0, samples_checked = 0, cyc = 0, i;
   int q[$];
   backlight_control_status_regs #(.ID_VALUE(ID), .BOOST_LOW_CYCLES(20))
   i_dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .chip_enable_pin(en), .pwm_pin(pin), .pwm_pin_duty_out(pduty),
      .brightness_pwm_out(bpwm), .led_open_det(opn), .led_short_det(sht),
      .boost_output_low(blow), .over_temp_hot(hot),
      .over_temp_cooled(cool), .supply_input_low(uvl),
      .supply_input_recovered(uvr), .temperature_raw(traw),
      .brightness_level(blev), .brightness_source_select(src),
      .backlight_on(bl), .led_drive(led), .boost_enable(boost),
      .fault_pin_out(fout), .fault_pin_oe_n(foen));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task chk(input string n, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input [7:0] a, d);
      @(negedge clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk) reg_wr = 0;
   endtask
   task rd(input [7:0] a);
      @(negedge clk) {reg_rd, reg_addr} = {1'b1, a};
      @(negedge clk) reg_rd = 0;
      r = reg_rdata;
   endtask
   task w(input int n);
      repeat (n) @(negedge clk);
   endtask
   function [31:0] nx(input [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task summarize;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      w(16);
      rstn = 1;
      chk("pin rst", foen, 8'h01);
      rd(8'h01);
      chk("ctrl", r, 8'h00);
      rd(8'h04);
      chk("force", r, 8'h00);
      wr(8'h03, 8'hff);
      rd(8'h03);
      chk("id", r, ID);
      wr(8'h02, 8'hff);
      rd(8'h02);
      chk("flt", r, 8'h00);
      rd(8'h40);
      chk("unmapped", r, 8'h00);
      lf = nx(lf);
      f = lf[15:8];
      wr(8'h00, f);
      rd(8'h00);
      chk("bright", r, f);
      chk("bright out", blev, f);
      for (i = 0; i < 4; i++) begin
         wr(8'h01, 8'(i * 2 + 1));
         rd(8'h01);
         chk("ctrl", r, 8'(i * 2 + 1));
         chk("src", {6'h0, src}, 8'(i));
         chk("on", bl, 8'h01);
      end
      $display("test registers done");
      {pin, pduty, bpwm} = 9'h15a;
      w(4);
      chk("pass", led, 8'h0f);
      wr(8'h01, 8'h05);
      w(2);
      chk("reg src", led, 8'h0a);
      wr(8'h01, 8'h01);
      w(2);
      chk("pin src", led, 8'h05);
      lf = nx(lf);
      f = {4'h0, lf[3:0]};
      wr(8'h04, f);
      w(2);
      rd(8'h04);
      chk("force", r, f);
      chk("led", led, f | 8'h05);
      $display("test drive done");
      opn = 4'h1;
      w(6);
      opn = 4'h0;
      w(3);
      chk("pin", foen, 8'h00);
      chk("pin out", fout, 8'h00);
      rd(8'h02);
      chk("open", r, 8'h98);
      w(3);
      chk("pin", foen, 8'h01);
      rd(8'h02);
      chk("clear", r, 8'h00);
      sht = 4'h6;
      w(6);
      sht = 4'h0;
      w(3);
      rd(8'h02);
      chk("short", r, 8'h68);
      opn = 4'h8;
      w(4);
      opn = 4'h0;
      en = 0;
      w(4);
      en = 1;
      w(4);
      rd(8'h02);
      chk("en clear", r, 8'h00);
      chk("boost", boost, 8'h01);
      blow = 1;
      w(20);
      chk("no ocp", boost, 8'h01);
      w(10);
      chk("ocp", boost, 8'h00);
      blow = 0;
      w(3);
      rd(8'h02);
      chk("ocp", r, 8'h04);
      w(4);
      chk("restart", boost, 8'h01);
      $display("test faults done");
      for (i = 0; i < 2; i++) begin
         {hot, uvl} = i ? 2'b01 : 2'b10;
         w(8);
         {hot, uvl} = 2'b00;
         w(3);
         chk("off", {3'h0, boost, led}, 8'h00);
         rd(8'h02);
         chk("flag", r, i ? 8'h01 : 8'h02);
         w(3);
         chk("held", boost, 8'h00);
         {cool, uvr} = i ? 2'b01 : 2'b10;
         w(5);
         {cool, uvr} = 2'b00;
         w(3);
         chk("back", boost, 8'h01);
      end
      $display("test shutdown done");
      repeat (4) begin
         lf = nx(lf);
         traw = lf[10:0];
         q.push_back(traw);
         rd(8'h05);
         chk("t hi", r, traw[10:3]);
         traw = ~traw;
         rd(8'h06);
         i = q.pop_front();
         chk("t lo", r, {i[2:0], 5'h00});
         wr(8'h05, 8'hff);
         rd(8'h05);
         chk("t ro", r, traw[10:3]);
      end
      $display("test temperature done");
      summarize();
   end
endmodule
